/* design/dwp_pkg.sv */
// Constants shared by the dual wiper position store
`default_nettype none
package dwp_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [4:0] WIPER_A_OFS  = 5'h00; // Volatile wiper, channel A
  localparam logic [4:0] WIPER_B_OFS  = 5'h04; // Volatile wiper, channel B
  localparam logic [4:0] PUWV_A_OFS   = 5'h08; // Stored power-up value, A
  localparam logic [4:0] PUWV_B_OFS   = 5'h0c; // Stored power-up value, B
  localparam logic [4:0] ACCESS_OFS   = 5'h10; // access_control_reg
  localparam logic [4:0] STATUS_OFS   = 5'h14; // Read-only status
  // Field positions in access_control_reg
  localparam int ACR_SHDN_A_BIT = 0;        // Channel A shutdown
  localparam int ACR_SHDN_B_BIT = 1;        // Channel B shutdown
  localparam int ACR_VOL_BIT    = 7;        // volatile_only_select
  // Field positions in the status register
  localparam int STAT_BUSY_BIT  = 0;        // Non-volatile write in progress
  localparam int STAT_READY_BIT = 1;        // Power-up recall finished
  // Reset and factory values
  localparam logic [7:0] PUWV_FACTORY = 8'h80; // Mid-scale, top bit only
  localparam logic [7:0] ACR_RESET    = 8'h00; // Both channels run, NV writes on
  localparam logic [7:0] WIPER_RESET  = 8'h00; // Before the recall completes
  // Timing
  localparam int CLK_HZ       = 50_000_000; // System clock rate
  localparam int NV_WRITE_MS  = 20;         // Non-volatile write cycle time
  localparam int RECALL_US    = 100;        // Longest power-up recall time
  // Least time rounds up; 20 ms is an exact count at 50 MHz
  localparam int NV_WRITE_CYC = (NV_WRITE_MS * CLK_HZ + 999) / 1000;
  // Longest time rounds down
  localparam int RECALL_CYC   = RECALL_US * (CLK_HZ / 1_000_000);
endpackage : dwp_pkg
`default_nettype wire

/* design/dwp_nv_store.sv */
// Non-volatile power-up wiper value cells with write cycle timer
`default_nettype none
module dwp_nv_store #(
  parameter int WRITE_CYC = dwp_pkg::NV_WRITE_CYC  // Write cycle length in clocks
) (
  input  wire logic       clk_i,          // System clock
  input  wire logic       rst_i,          // Synchronous reset, timer only
  input  wire logic       factory_load_i, // Loads the factory value into both cells
  input  wire logic       wr_i,           // Start a write of one cell
  input  wire logic       wr_sel_b_i,     // 0 = channel A cell, 1 = channel B cell
  input  wire logic [7:0] wr_data_i,      // Value to store
  output logic            busy_o,         // Write cycle in progress
  output logic      [7:0] value_a_o,      // Stored value, channel A
  output logic      [7:0] value_b_o       // Stored value, channel B
);
  localparam int TW = $clog2(WRITE_CYC + 1);

  // Cells are deliberately left out of rst_i so they outlive a power cycle
  logic [7:0]    cell_ff [2];  // Indexed by channel
  logic [7:0]    nxt_cell [2];
  logic [TW-1:0] timer_ff;     // Remaining write cycle clocks
  logic [TW-1:0] nxt_timer;

  // Next cell contents and write cycle timer
  always_comb
  begin
    nxt_cell  = cell_ff;
    nxt_timer = timer_ff;
    if (factory_load_i)
    begin
      nxt_cell[0] = dwp_pkg::PUWV_FACTORY;
      nxt_cell[1] = dwp_pkg::PUWV_FACTORY;
    end
    else if (wr_i && timer_ff == '0)
    begin
      // A write while a cycle runs is dropped; the host must wait
      nxt_cell[wr_sel_b_i] = wr_data_i;
      nxt_timer            = TW'(WRITE_CYC);
    end
    else if (timer_ff != '0)
    begin
      nxt_timer = timer_ff - TW'(1);
    end
  end

  // Cells hold across reset; the timer does not
  always_ff @(posedge clk_i)
  begin
    cell_ff <= nxt_cell;
    if (rst_i)
      timer_ff <= '0;
    else
      timer_ff <= nxt_timer;
  end

  assign busy_o    = (timer_ff != '0);
  assign value_a_o = cell_ff[0];
  assign value_b_o = cell_ff[1];
endmodule : dwp_nv_store
`default_nettype wire

/* design/dwp_top.sv */
// Dual wiper position store: wiper registers, access control and recall
// Notes on behaviour
// - Two channels independent, no shared state; here both share the stored-write timer and volatile_only_select
// - Eight-bit volatile code selects each tap
// - Code zero puts wiper at low end
// - Rising code moves tap monotonically upward
// - Stored power-up value survives power removal
// - Power-up copies stored value into wiper
// - Factory default stored value is mid-scale
// - Volatile-only setting lets writes skip storage
// - Volatile write moves wiper, storage unchanged
// - Wiper moves within 600 ns
// - Leaving shutdown restores wiper within 800 ns
// - Stored write takes 20 ms; wait
// - Recall done, interface ready within 100 us
//
// Implementation choices: the register addresses and register access over Wishbone.
`default_nettype none
module dwp_top #(
  parameter int NV_WRITE_CYC = dwp_pkg::NV_WRITE_CYC, // Clocks per stored write
  parameter int RECALL_CYC   = dwp_pkg::RECALL_CYC    // Clocks from reset to ready
) (
  input  wire logic        clk_i,          // 50 MHz system clock
  input  wire logic        rst_i,          // Synchronous reset, stands for power-on
  input  wire logic        factory_load_i, // Factory programming of stored values
  // Classic Wishbone slave
  input  wire logic        cyc_i,          // Bus cycle
  input  wire logic        stb_i,          // Strobe
  input  wire logic        we_i,           // Write enable
  input  wire logic [4:0]  adr_i,          // Byte address
  input  wire logic [3:0]  sel_i,          // Byte lane selects
  input  wire logic [31:0] dat_i,          // Write data
  output logic      [31:0] dat_o,          // Read data
  output logic             ack_o,          // Acknowledge
  // Potentiometer controls
  output logic       [7:0] wiper_a_o,      // Tap code, channel A
  output logic       [7:0] wiper_b_o,      // Tap code, channel B
  output logic             shutdown_a_o,   // Channel A high end opened
  output logic             shutdown_b_o,   // Channel B high end opened
  output logic             ready_o,        // Recall done, bus writes accepted
  output logic             nv_busy_o       // Stored write cycle running
);
  localparam int RW = $clog2(RECALL_CYC + 1);

  typedef enum logic [0:0] {DWP_RECALL, DWP_RUN} dwp_state_t;

  // Aligned word offset from a byte address
  function automatic logic [4:0] dwp_word(input logic [4:0] adr);
    dwp_word = {adr[4:2], 2'b00};
  endfunction : dwp_word

  dwp_state_t    state_ff;       // Recall or running
  dwp_state_t    nxt_state;
  logic [RW-1:0] recall_cnt_ff;  // Clocks left before recall completes
  logic [RW-1:0] nxt_recall_cnt;
  logic [7:0]    wiper_ff [2];   // Volatile wiper codes, by channel
  logic [7:0]    nxt_wiper [2];
  logic [7:0]    acr_ff;         // access_control_reg
  logic [7:0]    nxt_acr;
  logic          ack_ff;         // Bus answer
  logic          nxt_ack;
  logic [31:0]   rdata_ff;       // Bus read data
  logic [31:0]   nxt_rdata;
  logic          nv_wr;          // Start a stored write
  logic          nv_sel_b;       // Which cell
  logic [7:0]    nv_data;        // Value for the cell
  logic          nv_busy;        // Stored write running
  logic [7:0]    nv_val_a;       // Stored value A
  logic [7:0]    nv_val_b;       // Stored value B
  logic          bus_req;        // New request this cycle
  logic          bus_wr;         // New write with low lane enabled
  logic [4:0]    word;           // Decoded word offset

  // Non-volatile cells
  dwp_nv_store #(
    .WRITE_CYC (NV_WRITE_CYC)
  ) u_nv (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .factory_load_i (factory_load_i),
    .wr_i           (nv_wr),
    .wr_sel_b_i     (nv_sel_b),
    .wr_data_i      (nv_data),
    .busy_o         (nv_busy),
    .value_a_o      (nv_val_a),
    .value_b_o      (nv_val_b)
  );

  // Request decode; ack is answered one clock after the strobe
  always_comb
  begin
    bus_req = cyc_i && stb_i && !ack_ff;
    bus_wr  = bus_req && we_i && sel_i[0] && (state_ff == DWP_RUN);
    word    = dwp_word(adr_i);
  end

  // Recall sequencer: wait, then copy stored values into the wipers
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_recall_cnt = recall_cnt_ff;
    unique case (state_ff)
      DWP_RECALL:
      begin
        if (recall_cnt_ff == '0)
          nxt_state = DWP_RUN;
        else
          nxt_recall_cnt = recall_cnt_ff - RW'(1);
      end
      DWP_RUN:
      begin
        nxt_recall_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff      <= DWP_RECALL;
      recall_cnt_ff <= RW'(RECALL_CYC - 1);
    end
    else
    begin
      state_ff      <= nxt_state;
      recall_cnt_ff <= nxt_recall_cnt;
    end
  end

  // Wiper, access control and stored-write requests
  always_comb
  begin
    nxt_wiper = wiper_ff;
    nxt_acr   = acr_ff;
    nv_wr     = 1'b0;
    nv_sel_b  = 1'b0;
    nv_data   = dat_i[7:0];
    if (state_ff == DWP_RECALL && recall_cnt_ff == '0)
    begin
      nxt_wiper[0] = nv_val_a;
      nxt_wiper[1] = nv_val_b;
    end
    else if (bus_wr)
    begin
      unique case (word)
        dwp_pkg::WIPER_A_OFS, dwp_pkg::WIPER_B_OFS:
        begin
          // Each channel touches only its own register
          nxt_wiper[word[2]] = dat_i[7:0];
          nv_sel_b           = word[2];
          // Without volatile-only the value is also stored
          nv_wr = !acr_ff[dwp_pkg::ACR_VOL_BIT];
        end
        dwp_pkg::ACCESS_OFS:
        begin
          // Shutdown leaves the code intact, so leaving it restores
          // the wiper on the very next clock
          nxt_acr = dat_i[7:0];
        end
        default:
        begin
          // Stored values and status are read-only here
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wiper_ff[0] <= dwp_pkg::WIPER_RESET;
      wiper_ff[1] <= dwp_pkg::WIPER_RESET;
      acr_ff      <= dwp_pkg::ACR_RESET;
    end
    else
    begin
      wiper_ff <= nxt_wiper;
      acr_ff   <= nxt_acr;
    end
  end

  // Bus answer and read data
  always_comb
  begin
    nxt_ack   = bus_req;
    nxt_rdata = 32'h0000_0000;
    if (bus_req && !we_i)
    begin
      unique case (word)
        dwp_pkg::WIPER_A_OFS: nxt_rdata[7:0] = wiper_ff[0];
        dwp_pkg::WIPER_B_OFS: nxt_rdata[7:0] = wiper_ff[1];
        dwp_pkg::PUWV_A_OFS:  nxt_rdata[7:0] = nv_val_a;
        dwp_pkg::PUWV_B_OFS:  nxt_rdata[7:0] = nv_val_b;
        dwp_pkg::ACCESS_OFS:  nxt_rdata[7:0] = acr_ff;
        dwp_pkg::STATUS_OFS:
        begin
          nxt_rdata[dwp_pkg::STAT_BUSY_BIT]  = nv_busy;
          nxt_rdata[dwp_pkg::STAT_READY_BIT] = (state_ff == DWP_RUN);
        end
        default:              nxt_rdata = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Output flops; code drives the tap directly, zero at the low end
  logic [7:0] wa_ff;  // Registered tap code A
  logic [7:0] wb_ff;  // Registered tap code B
  logic       sa_ff;  // Registered shutdown A
  logic       sb_ff;  // Registered shutdown B
  logic       rdy_ff; // Registered ready
  logic       bsy_ff; // Registered busy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wa_ff  <= dwp_pkg::WIPER_RESET;
      wb_ff  <= dwp_pkg::WIPER_RESET;
      sa_ff  <= 1'b0;
      sb_ff  <= 1'b0;
      rdy_ff <= 1'b0;
      bsy_ff <= 1'b0;
    end
    else
    begin
      wa_ff  <= nxt_wiper[0];
      wb_ff  <= nxt_wiper[1];
      sa_ff  <= nxt_acr[dwp_pkg::ACR_SHDN_A_BIT];
      sb_ff  <= nxt_acr[dwp_pkg::ACR_SHDN_B_BIT];
      rdy_ff <= (nxt_state == DWP_RUN);
      bsy_ff <= nv_busy;
    end
  end

  assign wiper_a_o    = wa_ff;
  assign wiper_b_o    = wb_ff;
  assign shutdown_a_o = sa_ff;
  assign shutdown_b_o = sb_ff;
  assign ready_o      = rdy_ff;
  assign nv_busy_o    = bsy_ff;
  assign ack_o        = ack_ff;
  assign dat_o        = rdata_ff;
endmodule : dwp_top
`default_nettype wire

/* testbench/dwp_properties.sv */
// Port-level checks for the dual wiper position store
`default_nettype none
module dwp_properties #(
  parameter int NV_WRITE_CYC = 20, // Clocks per stored write
  parameter int RECALL_CYC   = 4   // Clocks from reset to ready
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [7:0]  wiper_a_o,
  input wire logic [7:0]  wiper_b_o,
  input wire logic        shutdown_a_o,
  input wire logic        ready_o,
  input wire logic        nv_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        req;                // Request taken at this edge
  logic        wr_ok;              // Write that may land in a register
  logic [23:0] rcnt_ff, nxt_rcnt;  // Cycles spent waiting for recall
  logic [23:0] bcnt_ff, nxt_bcnt;  // Cycles of one stored write
  assign req   = cyc_i && stb_i && !ack_o;
  assign wr_ok = req && we_i && sel_i[0] && ready_o;
  // Counters clear in reset so a second power-up starts from zero
  always_comb
  begin
    nxt_rcnt = (rst_i || ready_o) ? 24'h0 : rcnt_ff + 24'h1;
    nxt_bcnt = (rst_i || !nv_busy_o) ? 24'h0 : bcnt_ff + 24'h1;
  end
  // Counter registers
  always_ff @(posedge clk_i)
  begin
    rcnt_ff <= nxt_rcnt;
    bcnt_ff <= nxt_bcnt;
  end
  ack_one_cycle_a: assert property (req |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse one cycle after request");
  ack_has_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  wiper_a_write_a: assert property (wr_ok && adr_i[4:2] == 3'd0 |=>
    wiper_a_o == $past(dat_i[7:0])) else $error("wiper A not written");
  chan_b_apart_a: assert property (wr_ok && adr_i[4:2] == 3'd1 |=>
    wiper_b_o == $past(dat_i[7:0]) && $stable(wiper_a_o)) else $error("channel B write");
  partial_write_a: assert property (req && we_i && !sel_i[0] && ready_o |=>
    $stable(wiper_a_o) && $stable(wiper_b_o)) else $error("lane-less write moved wiper");
  shutdown_set_a: assert property (wr_ok && adr_i[4:2] == 3'd4 |=>
    shutdown_a_o == $past(dat_i[0]) && $stable(wiper_a_o)) else $error("shutdown A");
  read_wiper_a: assert property (req && !we_i && adr_i[4:2] == 3'd0 |=>
    dat_o[7:0] == $past(wiper_a_o)) else $error("wiper A read back wrong");
  recall_bound_a: assert property (rcnt_ff <= RECALL_CYC + 3)
    else $error("recall too slow");
  nv_write_len_a: assert property (bcnt_ff <= NV_WRITE_CYC + 1)
    else $error("stored write too long");
  // A stored write must also run its full length, not just stay under a ceiling
  nv_write_exact_a: assert property ($fell(nv_busy_o) |-> bcnt_ff == NV_WRITE_CYC)
    else $error("stored write not full length");
  cover property (wr_ok && adr_i[4:2] == 3'd0);
  cover property ($rose(ready_o));
  cover property ($rose(nv_busy_o));
endmodule : dwp_properties
`default_nettype wire

/* testbench/dwp_host_model.sv */
// Wishbone master standing in for the host bus controller
`default_nettype none
module dwp_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [4:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] wdat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 5'h00;
    sel_o = 4'h0;
    wdat_o = 32'h0;
  end
  // One classic cycle; waits for ack with no limit of its own
  task xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    wdat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1)
      @(posedge clk_i);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data goes to the inverse so stale values cannot pass
    wdat_o <= ~d;
  endtask : xfer
endmodule : dwp_host_model
`default_nettype wire

/* testbench/dual_wiper_position_store_tb.sv */
// Self-checking bench for the dual wiper position store
`default_nettype none
module dual_wiper_position_store_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NV_WRITE_CYC = 20; // Short stored write keeps the run brief
  localparam int RECALL_CYC   = 4;
  logic        clk_i = 1'b0, rst_i = 1'b1, factory_load_i = 1'b1;
  logic        cyc_i, stb_i, we_i, ack_o, ready_o, nv_busy_o, shutdown_a_o, shutdown_b_o;
  logic [4:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [7:0]  wiper_a_o, wiper_b_o;
  logic [7:0]  codes [4] = '{8'h00, 8'h01, 8'h7f, 8'hff};
  int          n_errors = 0, n_tests = 0, cycles = 0;
  always #10 clk_i = ~clk_i;
  dwp_top #(.NV_WRITE_CYC(NV_WRITE_CYC), .RECALL_CYC(RECALL_CYC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .factory_load_i(factory_load_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .wiper_a_o(wiper_a_o), .wiper_b_o(wiper_b_o),
    .shutdown_a_o(shutdown_a_o), .shutdown_b_o(shutdown_b_o), .ready_o(ready_o),
    .nv_busy_o(nv_busy_o));
  dwp_host_model host (.clk_i(clk_i), .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .wdat_o(dat_i));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    host.xfer(1'b1, a, {24'h0, d}, s, q);
  endtask : wr
  task rd(input logic [4:0] a);
    host.xfer(1'b0, a, 32'h0, 4'hf, q);
  endtask : rd
  // Reset stands for a power cycle; stored cells keep their values
  task power_up;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    while (ready_o !== 1'b1)
      @(posedge clk_i);
  endtask : power_up
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Cuts a hang short; the whole sequence needs well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    @(posedge clk_i);
    factory_load_i <= 1'b0;
    power_up();
    chk(wiper_a_o, 32'h80);
    chk(wiper_b_o, 32'h80);
    $display("test factory recall done");
    wr(dwp_pkg::ACCESS_OFS, 8'h80);
    foreach (codes[i])
    begin
      wr(dwp_pkg::WIPER_A_OFS, codes[i]);
      chk(wiper_a_o, codes[i]);
      chk(wiper_b_o, 32'h80);
    end
    rd(dwp_pkg::WIPER_A_OFS);
    chk(q, 32'hff);
    rd(dwp_pkg::PUWV_A_OFS);
    chk(q, 32'h80);
    wr(dwp_pkg::WIPER_A_OFS, 8'h55, 4'h0);
    chk(wiper_a_o, 32'hff);
    wr(dwp_pkg::ACCESS_OFS, 8'h81);
    chk({shutdown_b_o, shutdown_a_o, wiper_a_o}, {2'b01, 8'hff});
    wr(dwp_pkg::ACCESS_OFS, 8'h80);
    chk({shutdown_a_o, wiper_a_o}, {1'b0, 8'hff});
    power_up();
    chk(wiper_a_o, 32'h80);
    $display("test volatile writes done");
    wr(dwp_pkg::WIPER_B_OFS, 8'h5a);
    chk(wiper_b_o, 32'h5a);
    @(posedge clk_i);
    chk(nv_busy_o, 32'h1);
    // Host waits out the stored write before relying on it
    repeat (NV_WRITE_CYC + 5) if (nv_busy_o === 1'b1) @(posedge clk_i);
    chk(nv_busy_o, 32'h0);
    rd(dwp_pkg::PUWV_B_OFS);
    chk(q, 32'h5a);
    rd(dwp_pkg::STATUS_OFS);
    chk(q, 32'h2);
    rd(5'h18);
    chk(q, 32'h0);
    // Power cycle with a write issued during recall; it must be refused
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(dwp_pkg::WIPER_B_OFS, 8'h11);
    while (ready_o !== 1'b1)
      @(posedge clk_i);
    chk(nv_busy_o, 32'h0);
    chk(wiper_b_o, 32'h5a);
    chk(wiper_a_o, 32'h80);
    rd(dwp_pkg::WIPER_B_OFS);
    chk(q, 32'h5a);
    $display("test stored write done");
    end_sim();
  end
endmodule : dual_wiper_position_store_tb
bind dwp_top dwp_properties #(.NV_WRITE_CYC(NV_WRITE_CYC), .RECALL_CYC(RECALL_CYC)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .wiper_a_o(wiper_a_o),
  .wiper_b_o(wiper_b_o), .shutdown_a_o(shutdown_a_o), .ready_o(ready_o),
  .nv_busy_o(nv_busy_o));
`default_nettype wire
